// ==== src/tpm_pwm.sv ====
// Timer PWM mode unit with APB registers, triggers and two PWM lines.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [RL1] Reload loads 0, period or 1, starts.
// [RL2] Start ignored while running; reload then only clears prescaler.
// [RL3] Start keeps count, sets direction by mode.
// [RL4] Halt-on-abort: kill stops until reload/start.
// [RL5] Async kill blanks outputs while kill active.
// [RL6] Aligned kill blanks until clean terminal count.
// [RL7] Each active count steps one in direction.
// [RL8] Swap exchanges enabled pairs at terminal count.
// [RL9] Software command or pin rising edge triggers swap.
// [RL10] Swap pends while running, dropped when idle.
// [RL11] One-shot stops on overflow in up mode, else on underflow.
// [RL12] Count range follows direction mode.
// [RL13] Compare hit entering (up/down) or leaving.
// [RL14] Underflow when decrementing away from zero.
// [RL15] Overflow when incrementing away from period.
// [RL16] Terminal count chosen from events by mode.
// [RL17] Main and complement outputs from one line.
// [RL18] Events toggle, set or clear the line.
// [RL19] Overflow/underflow action before compare action.
// [RL20] Polarity bits invert main and complement.
// [RL21] Shadow writes act only after swap.
// [RL22] Prescaler divides counting into active counts.
// [RL23] Stopped rests at polarity, disabled low.
// [RL24] Up/down reload treats previous count as zero.
// [RL25] All count values are sixteen bits.
module tpm_pwm
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Hardware trigger pins, synchronised inside; reload, start and swap edge-qualified, kill and count used as levels.
  input  wire logic        trig_reload,
  input  wire logic        trig_start,
  input  wire logic        trig_kill,
  input  wire logic        trig_count,
  input  wire logic        trig_swap,
  // PWM lines.
  output logic             pwm_out,
  output logic             pwm_compl_out
);
  import tpm_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree.
  logic [4:0] s1_r, s2_r, s3_r, pin_r, pin_d_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_r  <= 5'h00;
      s2_r  <= 5'h00;
      s3_r  <= 5'h00;
      pin_r <= 5'h00;
      pin_d_r <= 5'h00;
    end else begin
      s1_r <= {trig_swap, trig_count, trig_kill, trig_start, trig_reload};
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_d_r <= pin_r; // Edge reference; count and kill are used as levels.
      for (int i = 0; i < 5; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          pin_r[i] <= s3_r[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [31:0] ctrl_r;
  logic [15:0] count_r, per_r, persh_r, cmp_r, cmpsh_r;
  logic [5:0]  act_r;
  logic [3:0]  cmd_r;
  logic        wr_en;
  assign wr_en = psel && penable && pwrite;

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a <= TPM_OFF_STAT) && (a[1:0] == 2'h0);
  endfunction

  logic       enabled;
  logic       halt_kill, align_kill, cswap_en, pswap_en, oneshot;
  logic [1:0] dir_mode, pol;
  logic [7:0] pre_div;
  assign enabled    = ctrl_r[TPM_CTRL_EN];
  assign oneshot    = ctrl_r[TPM_CTRL_ONESH];
  assign halt_kill  = ctrl_r[TPM_CTRL_HALT];
  assign align_kill = ctrl_r[TPM_CTRL_ALIGN];
  assign cswap_en   = ctrl_r[TPM_CTRL_CSWAP];
  assign pswap_en   = ctrl_r[TPM_CTRL_PSWAP];
  assign dir_mode   = ctrl_r[TPM_CTRL_DIR_LO +: 2];
  assign pol        = ctrl_r[TPM_CTRL_POL_LO +: 2];
  assign pre_div    = ctrl_r[TPM_CTRL_PRE_LO +: 8];

  // Combined events: software command pulse or pin edge / level; count comes from the pin level alone.
  logic ev_reload, ev_start, ev_kill, ev_swap, ev_count;
  assign ev_reload = cmd_r[TPM_CMD_RELOAD] || (pin_r[0] && !pin_d_r[0]);
  assign ev_start  = cmd_r[TPM_CMD_START] || (pin_r[1] && !pin_d_r[1]);
  assign ev_kill   = cmd_r[TPM_CMD_STOP] || pin_r[2];
  assign ev_count  = pin_r[3];
  assign ev_swap   = cmd_r[TPM_CMD_SWAP] || (pin_r[4] && !pin_d_r[4]);

  //////////////////////////////////////////////////////////////////////////
  // Prescaler: active count once every pre_div+1 count events.
  logic [7:0] pre_r;
  logic       active;
  assign active = ev_count && (pre_r == pre_div); // [RL22]
  tpm_state_e state_r;
  logic       running;
  assign running = (state_r == TPM_RUN);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pre_r <= 8'h00;
    end else if (!running || ev_reload) begin
      pre_r <= 8'h00;
    end else if (ev_count) begin
      pre_r <= active ? 8'h00 : pre_r + 8'h01; // [RL22]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Counter events, all 16 bits wide.
  logic up_r, first_r;
  logic ovf, udf, hit, tc;
  logic [15:0] cnt_nxt;
  logic        is_ud;
  assign is_ud = dir_mode[1];
  assign ovf = running && active && up_r && (count_r == per_r);   // [RL15] [RL25]
  assign udf = running && active && !up_r && (count_r == 16'h0000); // [RL14]

  always_comb begin
    if (up_r) begin
      cnt_nxt = (count_r == per_r) ? (is_ud ? count_r - 16'h0001 : 16'h0000)
                                   : count_r + 16'h0001; // [RL7] [RL12]
    end else begin
      cnt_nxt = (count_r == 16'h0000) ? (is_ud ? 16'h0001 : per_r)
                                      : count_r - 16'h0001; // [RL7] [RL12]
    end
  end

  // Compare hit on entering in up or down mode, on leaving in up/down modes.
  always_comb begin
    hit = 1'b0;
    if (running && active) begin
      if (is_ud) begin
        hit = first_r ? (cmp_r == 16'h0000) : (count_r == cmp_r); // [RL13] [RL24]
      end else begin
        hit = (cnt_nxt == cmp_r); // [RL13]
      end
    end
  end

  always_comb begin
    unique case (dir_mode)
      TPM_DIR_UP:   tc = ovf;
      TPM_DIR_UD2:  tc = ovf || udf;
      default:      tc = udf;
    endcase // [RL16]
  end

  //////////////////////////////////////////////////////////////////////////
  // Run state, direction and count value.
  logic can_go, stop_now;
  assign can_go   = enabled && !running && (ev_reload || ev_start); // [RL2]
  assign stop_now = (halt_kill && ev_kill) // [RL4]
                 || (oneshot && (dir_mode == TPM_DIR_UP ? ovf : udf)); // [RL11]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= TPM_IDLE;
      up_r    <= 1'b1;
      count_r <= 16'h0000;
      first_r <= 1'b0;
    end else if (!enabled) begin
      state_r <= TPM_IDLE;
      first_r <= 1'b0;
      if (wr_en && paddr == TPM_OFF_COUNT) count_r <= pwdata[15:0];
    end else if (can_go && !(halt_kill && ev_kill)) begin
      state_r <= TPM_RUN;
      up_r    <= (dir_mode != TPM_DIR_DOWN); // [RL3]
      if (ev_reload) begin
        count_r <= (dir_mode == TPM_DIR_UP) ? 16'h0000 :
                   (dir_mode == TPM_DIR_DOWN) ? per_r : 16'h0001; // [RL1]
        first_r <= is_ud; // [RL24]
      end
    end else if (running) begin
      if (active) begin
        count_r <= cnt_nxt; // [RL7]
        first_r <= 1'b0;
        if (ovf && is_ud) up_r <= 1'b0;
        if (udf && is_ud) up_r <= 1'b1;
      end
      if (stop_now) state_r <= TPM_IDLE; // [RL4] [RL11]
    end else if (wr_en && paddr == TPM_OFF_COUNT) begin
      count_r <= pwdata[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Swap pending flag; the new detection wins over the clear at tc.
  logic swap_pend_r, do_swap;
  assign do_swap = tc && swap_pend_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      swap_pend_r <= 1'b0;
    end else if (!running) begin
      swap_pend_r <= 1'b0; // [RL10]
    end else if (ev_swap) begin
      swap_pend_r <= 1'b1; // [RL10]
    end else if (do_swap) begin
      swap_pend_r <= 1'b0;
    end
  end

  // Active and shadow values; shadows only reach the waveform through swaps.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      per_r   <= TPM_PER_RST;
      persh_r <= TPM_PER_RST;
      cmp_r   <= 16'h0000;
      cmpsh_r <= 16'h0000;
    end else begin
      if (do_swap && pswap_en) begin
        per_r   <= persh_r; // [RL8] [RL21]
        persh_r <= per_r;
      end else begin
        if (wr_en && paddr == TPM_OFF_PER)   per_r   <= pwdata[15:0];
        if (wr_en && paddr == TPM_OFF_PERSH) persh_r <= pwdata[15:0];
      end
      if (do_swap && cswap_en) begin
        cmp_r   <= cmpsh_r; // [RL8] [RL21]
        cmpsh_r <= cmp_r;
      end else begin
        if (wr_en && paddr == TPM_OFF_CMP)   cmp_r   <= pwdata[15:0];
        if (wr_en && paddr == TPM_OFF_CMPSH) cmpsh_r <= pwdata[15:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Line generation: terminal event action first, compare action after.
  function automatic logic apply(input logic v, input logic [1:0] a);
    unique case (a)
      TPM_ACT_SET:   apply = 1'b1;
      TPM_ACT_CLEAR: apply = 1'b0;
      TPM_ACT_INV:   apply = !v;
      TPM_ACT_NONE:  apply = v;
    endcase
  endfunction

  logic line_r, line_nxt;
  always_comb begin
    line_nxt = line_r;
    if (ovf) line_nxt = apply(line_nxt, act_r[1:0]); // [RL18]
    if (udf) line_nxt = apply(line_nxt, act_r[3:2]); // [RL18]
    if (hit) line_nxt = apply(line_nxt, act_r[5:4]); // [RL19]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_r <= 1'b0;
    end else begin
      line_r <= line_nxt;
    end
  end

  // Kill blanking: async follows kill level, aligned holds to clean tc.
  logic blank_r, suppress;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blank_r <= 1'b0;
    end else if (!align_kill) begin
      blank_r <= 1'b0;
    end else if (ev_kill && !halt_kill) begin
      blank_r <= 1'b1; // [RL6]
    end else if (tc) begin
      blank_r <= 1'b0; // [RL6]
    end
  end

  assign suppress = !running || (!halt_kill && !align_kill && ev_kill) // [RL5]
                 || blank_r;

  // Outputs from flip-flops; disabled drives low, blanked rests at polarity.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_out       <= 1'b0;
      pwm_compl_out <= 1'b0;
    end else if (!enabled) begin
      pwm_out       <= 1'b0; // [RL23]
      pwm_compl_out <= 1'b0;
    end else if (suppress) begin
      pwm_out       <= pol[0]; // [RL23]
      pwm_compl_out <= pol[1];
    end else begin
      pwm_out       <= line_nxt ^ pol[0];  // [RL17] [RL20]
      pwm_compl_out <= !line_nxt ^ pol[1]; // [RL17] [RL20]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped or misaligned address.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= TPM_CTRL_RST;
      act_r  <= TPM_ACT_RST;
      cmd_r  <= 4'h0;
    end else begin
      cmd_r <= 4'h0;
      if (wr_en && paddr == TPM_OFF_CTRL) ctrl_r <= pwdata;
      if (wr_en && paddr == TPM_OFF_ACT)  act_r  <= pwdata[5:0];
      if (wr_en && paddr == TPM_OFF_CMD)  cmd_r  <= pwdata[3:0]; // [RL9]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok(paddr);
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          TPM_OFF_CTRL:  prdata <= ctrl_r;
          TPM_OFF_COUNT: prdata <= {16'h0000, count_r};
          TPM_OFF_PER:   prdata <= {16'h0000, per_r};
          TPM_OFF_PERSH: prdata <= {16'h0000, persh_r};
          TPM_OFF_CMP:   prdata <= {16'h0000, cmp_r};
          TPM_OFF_CMPSH: prdata <= {16'h0000, cmpsh_r};
          TPM_OFF_ACT:   prdata <= {26'h0, act_r};
          TPM_OFF_STAT:  prdata <= {28'h0000000, blank_r, swap_pend_r, up_r, running};
          default:       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions, all on the one clock and quiet while reset is high.
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_reload_up;
    (can_go && ev_reload && !ev_kill && dir_mode == TPM_DIR_UP) |=> (count_r == 16'h0000);
  endproperty
  a_reload_up: assert property (p_reload_up) else $error("reload up not zero"); // [RL1]
  property p_no_restart;
    (running && ev_reload && !active && enabled && !wr_en) |=> $stable(count_r);
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("restart while running"); // [RL2]
  property p_halt;
    (enabled && halt_kill && ev_kill) |=> !running;
  endproperty
  a_halt: assert property (p_halt) else $error("kill did not halt"); // [RL4]
  property p_async_kill;
    (enabled && !halt_kill && !align_kill && ev_kill) |=> (pwm_out == $past(pol[0]));
  endproperty
  a_async_kill: assert property (p_async_kill) else $error("async kill not blanking"); // [RL5]
  // The cycle after a disable still shows running, so enabled guards the step check.
  property p_step;
    (enabled && running && active && up_r && count_r != per_r && !stop_now && !can_go)
      |=> (count_r == $past(count_r) + 16'h0001);
  endproperty
  a_step: assert property (p_step) else $error("count step wrong"); // [RL7]
  property p_swap;
    (do_swap && cswap_en) |=> (cmp_r == $past(cmpsh_r));
  endproperty
  a_swap: assert property (p_swap) else $error("compare swap missing"); // [RL8]
  property p_swap_drop;
    !running |=> !swap_pend_r;
  endproperty
  a_swap_drop: assert property (p_swap_drop) else $error("swap kept while idle"); // [RL10]
  property p_disabled_low;
    !enabled |=> (!pwm_out && !pwm_compl_out);
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("disabled output high"); // [RL23]
  property p_oneshot;
    (oneshot && dir_mode == TPM_DIR_UP && ovf) |=> !running;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot kept running"); // [RL11]
  c_tc:    cover property (tc && hit);
  c_swap:  cover property (do_swap);
  c_blank: cover property (blank_r ##1 !blank_r);
endmodule

// ==== src/tpm_pkg.sv ====
// Package with constants, register map and types of the timer PWM mode unit.
package tpm_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [11:0] TPM_OFF_CTRL   = 12'h000;
  localparam logic [11:0] TPM_OFF_CMD    = 12'h004;
  localparam logic [11:0] TPM_OFF_COUNT  = 12'h008;
  localparam logic [11:0] TPM_OFF_PER    = 12'h00c;
  localparam logic [11:0] TPM_OFF_PERSH  = 12'h010;
  localparam logic [11:0] TPM_OFF_CMP    = 12'h014;
  localparam logic [11:0] TPM_OFF_CMPSH  = 12'h018;
  localparam logic [11:0] TPM_OFF_ACT    = 12'h01c;
  localparam logic [11:0] TPM_OFF_STAT   = 12'h020;

  // Control register field positions.
  localparam int TPM_CTRL_EN     = 0;
  localparam int TPM_CTRL_ONESH  = 1;
  localparam int TPM_CTRL_HALT   = 2;
  localparam int TPM_CTRL_ALIGN  = 3;
  localparam int TPM_CTRL_CSWAP  = 4;
  localparam int TPM_CTRL_PSWAP  = 5;
  localparam int TPM_CTRL_DIR_LO = 6;
  localparam int TPM_CTRL_POL_LO = 8;
  localparam int TPM_CTRL_PRE_LO = 16;

  // Command register bits, each a one-shot software trigger.
  localparam int TPM_CMD_RELOAD = 0;
  localparam int TPM_CMD_START  = 1;
  localparam int TPM_CMD_STOP   = 2;
  localparam int TPM_CMD_SWAP   = 3;

  // Reset values.
  localparam logic [31:0] TPM_CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] TPM_PER_RST  = 16'hffff;
  localparam logic [5:0]  TPM_ACT_RST  = 6'h00;

  // Counting directions.
  localparam logic [1:0] TPM_DIR_UP   = 2'h0;
  localparam logic [1:0] TPM_DIR_DOWN = 2'h1;
  localparam logic [1:0] TPM_DIR_UD1  = 2'h2;
  localparam logic [1:0] TPM_DIR_UD2  = 2'h3;

  // Line actions per event.
  localparam logic [1:0] TPM_ACT_SET   = 2'h0;
  localparam logic [1:0] TPM_ACT_CLEAR = 2'h1;
  localparam logic [1:0] TPM_ACT_INV   = 2'h2;
  localparam logic [1:0] TPM_ACT_NONE  = 2'h3;

  // Counter run state.
  typedef enum logic [1:0] {
    TPM_IDLE = 2'b01,
    TPM_RUN  = 2'b10
  } tpm_state_e;

endpackage

// ==== verif/tpm_trig_src.sv ====
// Trigger source and output load model for the timer PWM unit.
`timescale 1ns/1ns

module tpm_trig_src (
  // Clock.
  input  wire logic clk,
  // Loads on the PWM lines.
  input  wire logic pwm_out,
  input  wire logic pwm_compl_out,
  // Trigger pins.
  output logic      trig_reload,
  output logic      trig_start,
  output logic      trig_kill,
  output logic      trig_count,
  output logic      trig_swap
);
  logic [4:0] pin_r;

  // Pin order: reload, start, kill, count, swap.
  assign trig_reload = pin_r[0];
  assign trig_start  = pin_r[1];
  assign trig_kill   = pin_r[2];
  assign trig_count  = pin_r[3];
  assign trig_swap   = pin_r[4];

  // All pins rest low, so the edge filters see no spurious event.
  initial begin
    pin_r = 5'h00;
  end

  // Held levels change just after a rising edge, never on the sampling edge.
  task automatic set_pin(input int sel, input logic v);
    @(posedge clk);
    pin_r[sel] <= v;
  endtask

  // A pulse gives one clean rising and falling edge on the selected pin.
  task automatic pulse(input int sel, input int n);
    set_pin(sel, 1'b1);
    repeat (n) @(posedge clk);
    pin_r[sel] <= 1'b0;
  endtask

  // Lines are sampled mid-cycle where they are settled.
  task automatic count_hi(input int n, output int hi, output int chi);
    hi = 0;
    chi = 0;
    repeat (n) begin
      @(negedge clk);
      if (pwm_out === 1'b1) hi++;
      if (pwm_compl_out === 1'b1) chi++;
    end
  endtask
endmodule

// ==== verif/timer_pwm_mode_unit_test.sv ====
// Self-checking testbench of the timer PWM unit over APB and trigger pins.
`timescale 1ns/1ns

module timer_pwm_mode_unit_test;
  import tpm_pkg::*;
  logic        clk, rst, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, c0, c1;
  logic        pready, pslverr, e;
  logic        trig_reload, trig_start, trig_kill, trig_count, trig_swap;
  logic        pwm_out, pwm_compl_out;
  int          fails, compares, hi, chi;
  localparam logic [31:0] C_EN = 32'h1 << TPM_CTRL_EN;
  localparam logic [31:0] C_OS = 32'h1 << TPM_CTRL_ONESH;
  localparam logic [31:0] C_HA = 32'h1 << TPM_CTRL_HALT;
  localparam logic [31:0] C_CS = 32'h1 << TPM_CTRL_CSWAP;
  localparam logic [31:0] C_AL = 32'h1 << TPM_CTRL_ALIGN;
  localparam logic [31:0] C_PS = 32'h1 << TPM_CTRL_PSWAP;
  localparam logic [31:0] EXP_CNT [4] = '{32'h0, 32'h4, 32'h1, 32'h1};

  tpm_pwm tpm_pwm_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_reload(trig_reload), .trig_start(trig_start),
    .trig_kill(trig_kill), .trig_count(trig_count), .trig_swap(trig_swap),
    .pwm_out(pwm_out), .pwm_compl_out(pwm_compl_out));

  tpm_trig_src tpm_trig_src_inst (.clk(clk), .pwm_out(pwm_out),
    .pwm_compl_out(pwm_compl_out), .trig_reload(trig_reload), .trig_start(trig_start),
    .trig_kill(trig_kill), .trig_count(trig_count), .trig_swap(trig_swap));

  //////////////////////////////////////////////////////////////////////////////
  // 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // One comparison; a mismatch is reported and counted at once.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Single verdict point of the run.
  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // APB transfer; the request holds until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic w(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dq;
    logic        de;
    apb(1'b1, a, d, dq, de);
  endtask

  task automatic r(input logic [11:0] a, output logic [31:0] rq);
    logic de;
    apb(1'b0, a, 32'h0, rq, de);
  endtask

  // Watchdog well beyond the several hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    fails = 0;
    compares = 0;
    rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;

    // Reset values, disabled outputs low, unmapped place refused.
    r(TPM_OFF_CTRL, q);
    check("ctrl", q, TPM_CTRL_RST);
    r(TPM_OFF_PER, q);
    check("per", q, {16'h0, TPM_PER_RST});
    r(TPM_OFF_ACT, q);
    check("act", q, {26'h0, TPM_ACT_RST});
    check("out off", {pwm_out, pwm_compl_out}, 2'b00);
    apb(1'b0, 12'h024, 32'h0, q, e);
    check("unmapped err", e, 1'b1);
    check("unmapped data", q, 32'h0);
    $display("test reset done");

    // Reload start value and direction in every counting mode.
    w(TPM_OFF_PER, 32'h4);
    w(TPM_OFF_CMP, 32'h2);
    w(TPM_OFF_ACT, 32'h1c);
    for (int d = 0; d < 4; d++) begin
      w(TPM_OFF_CTRL, 32'h0);
      w(TPM_OFF_CTRL, C_EN | (32'(d) << TPM_CTRL_DIR_LO));
      w(TPM_OFF_CMD, 32'h1 << TPM_CMD_RELOAD);
      r(TPM_OFF_COUNT, q);
      check("reload count", q, EXP_CNT[d]);
      r(TPM_OFF_STAT, q);
      check("run up", q[1:0], (d == 1) ? 2'b01 : 2'b11);
    end
    $display("test reload done");

    // Count steps, prescaling, and reload refused while running.
    w(TPM_OFF_CTRL, 32'h0);
    w(TPM_OFF_PER, 32'hffff);
    w(TPM_OFF_CTRL, C_EN);
    w(TPM_OFF_CMD, 32'h1 << TPM_CMD_RELOAD);
    tpm_trig_src_inst.set_pin(3, 1'b1);
    repeat (10) @(posedge clk);
    r(TPM_OFF_COUNT, c0);
    repeat (19) @(posedge clk);
    r(TPM_OFF_COUNT, c1);
    check("steps", c1 - c0, 32'd22);
    w(TPM_OFF_CTRL, C_EN | (32'h1 << TPM_CTRL_PRE_LO));
    repeat (10) @(posedge clk);
    r(TPM_OFF_COUNT, c0);
    repeat (19) @(posedge clk);
    r(TPM_OFF_COUNT, c1);
    check("prescaled", c1 - c0, 32'd11);
    tpm_trig_src_inst.set_pin(3, 1'b0);
    repeat (10) @(posedge clk);
    r(TPM_OFF_COUNT, c0);
    w(TPM_OFF_CMD, 32'h1 << TPM_CMD_RELOAD);
    tpm_trig_src_inst.pulse(0, 3);
    repeat (8) @(posedge clk);
    r(TPM_OFF_COUNT, q);
    check("no restart", q, c0);
    $display("test count done");

    // Halt on kill rests the lines at polarity; start resumes without reload.
    w(TPM_OFF_CTRL, C_EN | C_HA | (32'h1 << TPM_CTRL_POL_LO));
    tpm_trig_src_inst.pulse(2, 3);
    repeat (8) @(posedge clk);
    r(TPM_OFF_STAT, q);
    check("halted", q[0], 1'b0);
    check("rest pol", {pwm_out, pwm_compl_out}, 2'b10);
    tpm_trig_src_inst.pulse(1, 3);
    repeat (8) @(posedge clk);
    r(TPM_OFF_STAT, q);
    check("resumed", q[0], 1'b1);
    r(TPM_OFF_COUNT, q);
    check("start keeps", q, c0);
    $display("test halt done");

    // Swap while idle is dropped.
    w(TPM_OFF_CTRL, 32'h0);
    w(TPM_OFF_CTRL, C_EN | C_CS);
    w(TPM_OFF_CMD, 32'h1 << TPM_CMD_SWAP);
    r(TPM_OFF_STAT, q);
    check("idle swap", q[2], 1'b0);
    $display("test idle swap done");

    // Left-aligned wave: overflow sets, compare clears, 2 of 5 cycles high.
    w(TPM_OFF_PER, 32'h4);
    w(TPM_OFF_CMD, 32'h1 << TPM_CMD_RELOAD);
    tpm_trig_src_inst.set_pin(3, 1'b1);
    repeat (10) @(posedge clk);
    tpm_trig_src_inst.count_hi(50, hi, chi);
    check("wave hi", hi, 32'd20);
    check("compl hi", chi, 32'd30);
    w(TPM_OFF_CMPSH, 32'h0);
    tpm_trig_src_inst.count_hi(50, hi, chi);
    check("shadow quiet", hi, 32'd20);
    tpm_trig_src_inst.pulse(4, 3);
    repeat (20) @(posedge clk);
    r(TPM_OFF_CMP, q);
    check("cmp swapped", q, 32'h0);
    r(TPM_OFF_CMPSH, q);
    check("shadow swapped", q, 32'h2);
    r(TPM_OFF_PER, q);
    check("per kept", q, 32'h4);
    tpm_trig_src_inst.count_hi(50, hi, chi);
    check("coincide", hi, 32'd0);
    $display("test wave done");

    // Async kill blanks both lines only while the kill pin is high.
    w(TPM_OFF_CMP, 32'h2);
    tpm_trig_src_inst.set_pin(2, 1'b1);
    repeat (10) @(posedge clk);
    tpm_trig_src_inst.count_hi(30, hi, chi);
    check("killed", {hi[15:0], chi[15:0]}, 32'h0);
    tpm_trig_src_inst.set_pin(2, 1'b0);
    repeat (10) @(posedge clk);
    tpm_trig_src_inst.count_hi(50, hi, chi);
    check("unkilled", hi, 32'd20);
    $display("test kill done");

    // Aligned kill blanks past the kill until a clean terminal count; period swaps.
    w(TPM_OFF_CTRL, C_EN | C_AL | C_PS);
    w(TPM_OFF_PERSH, 32'h6);
    w(TPM_OFF_CMD, 32'h1 << TPM_CMD_SWAP);
    tpm_trig_src_inst.pulse(2, 3);
    repeat (2) @(posedge clk);
    r(TPM_OFF_STAT, q);
    check("blank set", q[3], 1'b1);
    repeat (20) @(posedge clk);
    r(TPM_OFF_STAT, q);
    check("blank clear", q[3], 1'b0);
    r(TPM_OFF_PER, q);
    check("per swapped", q, 32'h6);
    $display("test aligned kill done");

    // One-shot stops after one period.
    w(TPM_OFF_CTRL, 32'h0);
    w(TPM_OFF_CTRL, C_EN | C_OS);
    w(TPM_OFF_CMD, 32'h1 << TPM_CMD_RELOAD);
    repeat (30) @(posedge clk);
    r(TPM_OFF_STAT, q);
    check("one shot", q[0], 1'b0);
    $display("test one shot done");
    end_sim();
  end
endmodule
